// ---- palette_pkg.sv ----
package palette_pkg;

    localparam int INDEX_W     = 8;
    localparam int COLOR_W     = 8;
    localparam int ENTRY_W     = 24;
    localparam int ENTRIES     = 256;
    localparam int SYNC_STAGES = 2;

    localparam logic [7:0]  INDEX_RESET = 8'h00;
    localparam logic [7:0]  INDEX_FIRST = 8'h00;
    localparam logic [7:0]  INDEX_LAST  = 8'hff;
    localparam logic [7:0]  INDEX_STEP  = 8'h01;
    localparam logic [7:0]  HOLD_RESET  = 8'h00;
    localparam logic [23:0] ENTRY_RESET = 24'h000000;

    // bit positions of the components inside one entry
    localparam int RED_LSB   = 16;
    localparam int GREEN_LSB = 8;
    localparam int BLUE_LSB  = 0;

    // gray path red -> green -> blue
    typedef enum logic [1:0] {
        PHASE_RED   = 2'b00,
        PHASE_GREEN = 2'b01,
        PHASE_BLUE  = 2'b11
    } color_phase_t;

    function automatic color_phase_t next_phase(input color_phase_t p);
        case (p)
            PHASE_RED:   next_phase = PHASE_GREEN;
            PHASE_GREEN: next_phase = PHASE_BLUE;
            default:     next_phase = PHASE_RED;
        endcase
    endfunction

    function automatic logic [7:0] next_index(input logic [7:0] idx);
        if (idx == INDEX_LAST) begin
            next_index = INDEX_FIRST;
        end else begin
            next_index = idx + INDEX_STEP;
        end
    endfunction

endpackage

// ---- palette_ram_if.sv ----
`timescale 1ns/10ps
interface palette_ram_if;
    logic        wr_en;
    logic [7:0]  wr_index;
    logic [23:0] wr_entry;
    logic [7:0]  rd_index;
    logic [23:0] rd_entry;

    modport host (output wr_en, output wr_index, output wr_entry, output rd_index,
                  input rd_entry);
    modport ram  (input wr_en, input wr_index, input wr_entry, input rd_index,
                  output rd_entry);
endinterface

// ---- palette_ram.sv ----
`timescale 1ns/10ps
module palette_ram #(
    parameter int ENTRIES = palette_pkg::ENTRIES
) (
    input  wire logic        i_core_clk,
    input  wire logic        i_rst_n,
    palette_ram_if.ram       host,
    input  wire logic [7:0]  i_disp_index,
    output logic      [23:0] o_disp_entry
);

    logic [23:0] mem_q [ENTRIES];

    // host write port, independent of the display port
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int i = 0; i < ENTRIES; i++) begin
                mem_q[i] <= palette_pkg::ENTRY_RESET;
            end
        end else if (host.wr_en) begin
            mem_q[host.wr_index] <= host.wr_entry;
        end
    end

    assign host.rd_entry = mem_q[host.rd_index];

    // display lookup never waits on host traffic
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_disp_entry <= palette_pkg::ENTRY_RESET;
        end else begin
            o_disp_entry <= mem_q[i_disp_index];
        end
    end

endmodule

// ---- palette_host_access_port.sv ----
// What this block does
// - the palette entry used for host access is chosen by an internal 8-bit index register.
// - the host can write the index register and read it back over the eight data lines.
// - a two-bit color phase counts modulo 3 and clears on any index register access.
// - the phase advances after every red, green or blue cycle to steer each byte.
// - on the blue write the held red and green join the blue byte into one 24-bit write.
// - after a blue read or blue write the index steps to the next entry.
// - the index wraps from the last entry to the first after its blue cycle.
// - select zero high with select one low routes data cycles to the palette entry.
// - both select lines low make the data byte an index register access.
// - host access uses a RAM port separate from the display lookup port.
// - writes capture red and green into holds; reads drive the selected component.
`timescale 1ns/10ps
module palette_host_access_port (
    input  wire logic        i_core_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_ce_n,
    input  wire logic        i_rd_wr,
    input  wire logic        i_select_line_zero,
    input  wire logic        i_select_line_one,
    input  wire logic [7:0]  i_host_data_bus,
    output logic      [7:0]  o_host_data_bus,
    output logic             o_host_data_oe_n,
    input  wire logic [7:0]  i_disp_index,
    output logic      [23:0] o_disp_entry,
    output logic      [7:0]  o_palette_index,
    output logic      [1:0]  o_color_phase_counter
);

    localparam int PIN_W = 12;

    logic [PIN_W-1:0]           pin_meta_q;
    logic [PIN_W-1:0]           pin_sync_q;
    logic                       ce_prev_q;
    logic [7:0]                 palette_index_q;
    palette_pkg::color_phase_t  phase_q;
    logic [7:0]                 red_hold_q;
    logic [7:0]                 green_hold_q;
    logic [7:0]                 rdata_q;
    logic                       oe_n_q;

    logic       ce_n_s;
    logic       rd_s;
    logic       sel0_s;
    logic       sel1_s;
    logic [7:0] data_s;
    logic       cyc_start;
    logic       cyc_end;
    logic       is_index;
    logic       is_pal;
    logic [7:0] sel_component;

    palette_ram_if ram_if ();

    // two-stage synchroniser on every host pin
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pin_meta_q <= {PIN_W{1'b1}};
            pin_sync_q <= {PIN_W{1'b1}};
        end else begin
            pin_meta_q <= {i_ce_n, i_rd_wr, i_select_line_zero, i_select_line_one,
                           i_host_data_bus};
            pin_sync_q <= pin_meta_q;
        end
    end

    assign ce_n_s = pin_sync_q[11];
    assign rd_s   = pin_sync_q[10];
    assign sel0_s = pin_sync_q[9];
    assign sel1_s = pin_sync_q[8];
    assign data_s = pin_sync_q[7:0];

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ce_prev_q <= 1'b1;
        end else begin
            ce_prev_q <= ce_n_s;
        end
    end

    assign cyc_start = ce_prev_q && !ce_n_s;
    assign cyc_end   = !ce_prev_q && ce_n_s;
    assign is_index  = !sel0_s && !sel1_s;
    assign is_pal    = sel0_s && !sel1_s;

    always_comb begin
        case (phase_q)
            palette_pkg::PHASE_RED:   sel_component = ram_if.rd_entry[palette_pkg::RED_LSB +: 8];
            palette_pkg::PHASE_GREEN: sel_component = ram_if.rd_entry[palette_pkg::GREEN_LSB +: 8];
            default:                  sel_component = ram_if.rd_entry[palette_pkg::BLUE_LSB +: 8];
        endcase
    end

    // index register: load, step after blue, wrap at the end
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            palette_index_q <= palette_pkg::INDEX_RESET;
        end else if (cyc_end) begin
            if (is_index && !rd_s) begin
                palette_index_q <= data_s;
            end else if (is_pal && phase_q == palette_pkg::PHASE_BLUE) begin
                palette_index_q <= palette_pkg::next_index(palette_index_q);
            end
        end
    end

    // color phase counter
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            phase_q <= palette_pkg::PHASE_RED;
        end else if (cyc_end) begin
            if (is_index) begin
                phase_q <= palette_pkg::PHASE_RED;
            end else if (is_pal) begin
                phase_q <= palette_pkg::next_phase(phase_q);
            end
        end
    end

    // red and green holds for the write sequence
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            red_hold_q   <= palette_pkg::HOLD_RESET;
            green_hold_q <= palette_pkg::HOLD_RESET;
        end else if (cyc_end && is_pal && !rd_s) begin
            if (phase_q == palette_pkg::PHASE_RED) begin
                red_hold_q <= data_s;
            end
            if (phase_q == palette_pkg::PHASE_GREEN) begin
                green_hold_q <= data_s;
            end
        end
    end

    // single 24-bit update on the blue write
    assign ram_if.wr_en    = cyc_end && is_pal && !rd_s && phase_q == palette_pkg::PHASE_BLUE;
    assign ram_if.wr_index = palette_index_q;
    assign ram_if.wr_entry = {red_hold_q, green_hold_q, data_s};
    assign ram_if.rd_index = palette_index_q;

    // read data is latched at the start of the pulse and held to its end
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rdata_q <= 8'h00;
        end else if (cyc_start && rd_s) begin
            if (is_index) begin
                rdata_q <= palette_index_q;
            end else if (is_pal) begin
                rdata_q <= sel_component;
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            oe_n_q <= 1'b1;
        end else if (cyc_end) begin
            oe_n_q <= 1'b1;
        end else if (cyc_start && rd_s && (is_index || is_pal)) begin
            oe_n_q <= 1'b0;
        end
    end

    palette_ram u_palette_ram (
        .i_core_clk   (i_core_clk),
        .i_rst_n      (i_rst_n),
        .host         (ram_if.host),
        .i_disp_index (i_disp_index),
        .o_disp_entry (o_disp_entry)
    );

    assign o_host_data_bus       = rdata_q;
    assign o_host_data_oe_n      = oe_n_q;
    assign o_palette_index       = palette_index_q;
    assign o_color_phase_counter = phase_q;

    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rst_n);

    sequence seq_index_end;
        cyc_end && is_index;
    endsequence

    sequence seq_pal_end;
        cyc_end && is_pal;
    endsequence

    sequence seq_blue_end;
        seq_pal_end ##0 (phase_q == palette_pkg::PHASE_BLUE);
    endsequence

    sequence seq_blue_write;
        seq_blue_end ##0 !rd_s;
    endsequence

    sequence seq_pal_write_end;
        seq_pal_end ##0 !rd_s;
    endsequence

    sequence seq_read_start;
        cyc_start && rd_s;
    endsequence

    sequence seq_read_pal;
        seq_read_start ##0 is_pal;
    endsequence

    sequence seq_other_start;
        cyc_start && !is_index && !is_pal;
    endsequence

    sequence seq_other_end;
        cyc_end && !is_index && !is_pal;
    endsequence

    AST_INDEX_LOAD: assert property (seq_index_end ##0 !rd_s |=>
        palette_index_q == $past(data_s))
        else $error("index not loaded from data");
    AST_PHASE_CLEAR: assert property (seq_index_end |=>
        phase_q == palette_pkg::PHASE_RED)
        else $error("phase not cleared on index access");
    AST_PHASE_ADV: assert property (seq_pal_end |=>
        phase_q == palette_pkg::next_phase($past(phase_q)))
        else $error("phase did not advance");
    AST_BLUE_WRITE: assert property (seq_blue_write |=>
        u_palette_ram.mem_q[$past(palette_index_q)]
            == $past({red_hold_q, green_hold_q, data_s}))
        else $error("blue write did not land in the entry");
    AST_INDEX_INC: assert property (
        seq_blue_end ##0 palette_index_q != palette_pkg::INDEX_LAST
        |=> palette_index_q == $past(palette_index_q) + palette_pkg::INDEX_STEP)
        else $error("index did not step after blue");
    AST_INDEX_WRAP: assert property (
        seq_blue_end ##0 palette_index_q == palette_pkg::INDEX_LAST
        |=> palette_index_q == palette_pkg::INDEX_FIRST)
        else $error("index did not wrap");
    AST_ONE_UPDATE: assert property (!cyc_end |=>
        $stable(palette_index_q) && $stable(phase_q))
        else $error("state changed outside pulse end");
    AST_READ_INDEX: assert property (seq_read_start ##0 is_index |=>
        !o_host_data_oe_n && o_host_data_bus == $past(palette_index_q))
        else $error("index read back wrong");
    AST_RELEASE: assert property (cyc_end |=> o_host_data_oe_n [*2])
        else $error("bus not released after pulse");
    AST_RED_HOLD: assert property (
        seq_pal_write_end ##0 phase_q == palette_pkg::PHASE_RED
        |=> red_hold_q == $past(data_s) && $stable(green_hold_q))
        else $error("red byte not held");
    AST_GREEN_HOLD: assert property (
        seq_pal_write_end ##0 phase_q == palette_pkg::PHASE_GREEN
        |=> green_hold_q == $past(data_s) && $stable(red_hold_q))
        else $error("green byte not held");
    AST_HOLD_STEADY: assert property (!(cyc_end && is_pal && !rd_s) |=>
        $stable(red_hold_q) && $stable(green_hold_q))
        else $error("holds changed without a palette write");

    AST_READ_RED: assert property (
        seq_read_pal ##0 phase_q == palette_pkg::PHASE_RED
        |=> !o_host_data_oe_n && o_host_data_bus
            == $past(u_palette_ram.mem_q[palette_index_q][palette_pkg::RED_LSB +: 8]))
        else $error("red component read wrong");
    AST_READ_GREEN: assert property (
        seq_read_pal ##0 phase_q == palette_pkg::PHASE_GREEN
        |=> !o_host_data_oe_n && o_host_data_bus
            == $past(u_palette_ram.mem_q[palette_index_q][palette_pkg::GREEN_LSB +: 8]))
        else $error("green component read wrong");
    AST_READ_BLUE: assert property (
        seq_read_pal ##0 phase_q == palette_pkg::PHASE_BLUE
        |=> !o_host_data_oe_n && o_host_data_bus
            == $past(u_palette_ram.mem_q[palette_index_q][palette_pkg::BLUE_LSB +: 8]))
        else $error("blue component read wrong");
    AST_READ_NO_WRITE: assert property (seq_pal_end ##0 rd_s |-> !ram_if.wr_en)
        else $error("palette read wrote the entry");
    AST_WRITE_ONLY_BLUE: assert property (ram_if.wr_en |-> seq_blue_write)
        else $error("entry written outside the blue write");
    AST_ENTRY_STEADY: assert property (!ram_if.wr_en |=>
        u_palette_ram.mem_q[$past(palette_index_q)]
            == $past(u_palette_ram.mem_q[palette_index_q]))
        else $error("entry changed without a blue write");
    AST_NO_STEP_MID: assert property (
        seq_pal_end ##0 phase_q != palette_pkg::PHASE_BLUE |=> $stable(palette_index_q))
        else $error("index stepped before blue");
    AST_INDEX_READ_KEEP: assert property (seq_index_end ##0 rd_s |=>
        $stable(palette_index_q))
        else $error("index read changed the index");

    AST_OTHER_IGNORED: assert property (seq_other_end |=>
        $stable(palette_index_q) && $stable(phase_q) && $stable(red_hold_q))
        else $error("refused select pair changed state");
    AST_OTHER_NO_DRIVE: assert property (seq_other_start |=> o_host_data_oe_n)
        else $error("refused select pair drove the bus");
    AST_WRITE_NO_DRIVE: assert property (cyc_start && !rd_s |=> o_host_data_oe_n)
        else $error("write cycle drove the bus");
    AST_DRIVE_STEADY: assert property (!o_host_data_oe_n && !cyc_end |=>
        $stable(o_host_data_bus))
        else $error("read data moved while driven");

    AST_DISP_LOOKUP: assert property (1'b1 |=>
        o_disp_entry == $past(u_palette_ram.mem_q[i_disp_index]))
        else $error("display lookup wrong");

endmodule

// ---- host_model.sv ----
`timescale 1ns/10ps
module host_model (
    input  wire logic       i_core_clk,
    input  wire logic [7:0] i_data,
    input  wire logic       i_oe_n,
    output logic            o_ce_n,
    output logic            o_rd_wr,
    output logic            o_sel_zero,
    output logic            o_sel_one,
    output logic      [7:0] o_data
);
    initial begin
        o_ce_n = 1'b1;
        o_rd_wr = 1'b1;
        o_sel_zero = 1'b0;
        o_sel_one = 1'b0;
        o_data = 8'h00;
    end

    // one low pulse per access, all qualifiers steady through it and after
    task automatic access(input logic rd, input logic s0, input logic s1,
                          input logic [7:0] wd, output logic [7:0] rdata,
                          output logic drove);
        @(negedge i_core_clk);
        o_rd_wr = rd;
        o_sel_zero = s0;
        o_sel_one = s1;
        o_data = wd;
        o_ce_n = 1'b0;
        repeat (6) @(negedge i_core_clk);
        rdata = i_data;
        drove = ~i_oe_n;
        o_ce_n = 1'b1;
        repeat (5) @(negedge i_core_clk);
        // released lines do not keep the last value
        o_data = ~wd;
    endtask
endmodule

// ---- testbench.sv ----
`timescale 1ns/10ps
module testbench;
    logic        i_core_clk = 1'b0;
    logic        i_rst_n;
    logic        ce_n;
    logic        rd_wr;
    logic        sel_zero;
    logic        sel_one;
    logic [7:0]  wdata;
    logic [7:0]  bus_rdata;
    logic        oe_n;
    logic [7:0]  disp_index;
    logic [23:0] disp_entry;
    logic [7:0]  palette_index;
    logic [1:0]  phase;
    logic [7:0]  rdata;
    logic        drove;
    int          failures = 0;
    int          n_compared = 0;
    int          cycles = 0;

    always #12.5 i_core_clk = ~i_core_clk;

    palette_host_access_port i_palette_host_access_port (
        .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_ce_n(ce_n), .i_rd_wr(rd_wr),
        .i_select_line_zero(sel_zero), .i_select_line_one(sel_one),
        .i_host_data_bus(wdata), .o_host_data_bus(bus_rdata), .o_host_data_oe_n(oe_n),
        .i_disp_index(disp_index), .o_disp_entry(disp_entry),
        .o_palette_index(palette_index), .o_color_phase_counter(phase));

    host_model i_host_model (
        .i_core_clk(i_core_clk), .i_data(bus_rdata), .i_oe_n(oe_n), .o_ce_n(ce_n),
        .o_rd_wr(rd_wr), .o_sel_zero(sel_zero), .o_sel_one(sel_one), .o_data(wdata));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic acc(input logic rd, input logic s0, input logic s1, input logic [7:0] wd);
        i_host_model.access(rd, s0, s1, wd, rdata, drove);
    endtask

    task automatic look(input logic [7:0] idx, input logic [23:0] exp);
        disp_index = idx;
        repeat (2) @(negedge i_core_clk);
        check(disp_entry, exp);
    endtask

    task automatic test_index_rw;
        acc(1'b0, 1'b0, 1'b0, 8'h05);
        check(palette_index, 8'h05);
        acc(1'b1, 1'b0, 1'b0, 8'h00);
        check({drove, rdata}, {1'b1, 8'h05});
        check(phase, palette_pkg::PHASE_RED);
    endtask

    task automatic test_entry(input logic rd, input logic [7:0] idx, input logic [23:0] ent);
        logic [1:0] ph [3];
        ph = '{palette_pkg::PHASE_GREEN, palette_pkg::PHASE_BLUE, palette_pkg::PHASE_RED};
        acc(1'b0, 1'b0, 1'b0, idx);
        for (int i = 0; i < 3; i++) begin
            acc(rd, 1'b1, 1'b0, ent[23-8*i -: 8]);
            check(phase, ph[i]);
            if (rd) begin
                check({drove, rdata}, {1'b1, ent[23-8*i -: 8]});
            end else begin
                check(drove, 1'b0);
            end
        end
        check(palette_index, 8'(idx + 8'h01));
    endtask

    task automatic test_mid_index;
        acc(1'b0, 1'b0, 1'b0, 8'h10);
        acc(1'b0, 1'b1, 1'b0, 8'h7e);
        check(phase, palette_pkg::PHASE_GREEN);
        acc(1'b1, 1'b0, 1'b0, 8'h00);
        check({rdata, 6'h00, phase}, {8'h10, 6'h00, palette_pkg::PHASE_RED});
    endtask

    task automatic test_refused;
        acc(1'b0, 1'b1, 1'b0, 8'h99);
        for (int i = 0; i < 2; i++) begin
            acc(i[0], 1'b1, 1'b1, 8'h5a);
            check(drove, 1'b0);
            acc(i[0], 1'b0, 1'b1, 8'h5a);
            check(drove, 1'b0);
        end
        check({palette_index, 6'h00, phase}, {8'h10, 6'h00, palette_pkg::PHASE_GREEN});
        check(oe_n, 1'b1);
        acc(1'b0, 1'b1, 1'b0, 8'h42);
        acc(1'b0, 1'b1, 1'b0, 8'h24);
        look(8'h10, 24'h994224);
        check(palette_index, 8'h11);
    endtask

    task automatic tally_and_finish;
        $display("compared=%0d failures=%0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    always @(posedge i_core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures++;
            tally_and_finish();
        end
    end

    initial begin
        i_rst_n = 1'b0;
        disp_index = 8'h00;
        repeat (10) @(negedge i_core_clk);
        i_rst_n = 1'b1;
        check({oe_n, palette_index, phase}, {1'b1, 8'h00, 2'b00});
        test_index_rw();
        test_entry(1'b0, 8'h05, 24'ha1b2c3);
        look(8'h05, 24'ha1b2c3);
        test_entry(1'b1, 8'h05, 24'ha1b2c3);
        test_entry(1'b0, 8'hff, 24'h112233);
        look(8'hff, 24'h112233);
        look(8'h06, 24'h000000);
        test_mid_index();
        test_refused();
        tally_and_finish();
    end
endmodule
